// *** scs_pkg.sv ***
package scs_pkg;

    // Core clock
    localparam int unsigned CLK_HZ        = 40_000_000;
    localparam int unsigned CLK_PERIOD_NS = 25;

    // Register offsets, byte-addressed on the plain port
    localparam logic [11:0] OFS_CUR_SRC   = 12'h88e;
    localparam logic [11:0] OFS_STATUS    = 12'h890;
    localparam logic [11:0] OFS_ENABLE    = 12'h891;
    localparam logic [11:0] OFS_TRIM      = 12'h892;
    localparam logic [11:0] OFS_FREQ      = 12'h893;

    // Field positions
    localparam int unsigned CUR_SRC_LSB   = 4;
    localparam int unsigned BIT_HF        = 6;
    localparam int unsigned BIT_MF        = 5;
    localparam int unsigned BIT_LF        = 4;
    localparam int unsigned BIT_ADC       = 2;
    localparam int unsigned TRIM_W        = 6;
    localparam int unsigned FREQ_W        = 3;

    // Reset-oscillator selection codes (also the current-source encoding)
    localparam logic [1:0] SRC_EXT        = 2'h3;
    localparam logic [1:0] SRC_HF_1M      = 2'h2;
    localparam logic [1:0] SRC_LF         = 2'h1;
    localparam logic [1:0] SRC_HF_32M     = 2'h0;

    // Frequency-select codes and reset values
    localparam logic [2:0] FREQ_16M       = 3'h4;
    localparam logic [2:0] FREQ_32M       = 3'h5;
    localparam logic [2:0] FREQ_MAX       = 3'h5;
    localparam logic [2:0] FREQ_RESET     = 3'h4;
    localparam logic [5:0] TRIM_RESET     = 6'h00;
    localparam logic [7:0] ENABLE_RESET   = 8'h00;

    // Nominal rates
    localparam longint unsigned HF_BASE_HZ = 1_000_000;
    localparam longint unsigned LF_HZ      = 31_000;
    localparam longint unsigned ADC_RC_HZ  = 600_000;

    // Phase increments of a 32-bit accumulator advanced once per mclk
    localparam logic [31:0] HF_INC_1MHZ = 32'((HF_BASE_HZ << 32) / CLK_HZ);
    localparam logic [31:0] LF_INC      = 32'((LF_HZ << 32) / CLK_HZ);
    localparam logic [31:0] ADC_INC     = 32'((ADC_RC_HZ << 32) / CLK_HZ);

    // Trim: one step is 1/512 of the nominal increment; slew per cycle
    localparam int unsigned TRIM_SHIFT  = 9;
    localparam logic [31:0] TRIM_SLEW   = 32'h0000_0400;

    // Medium-frequency division: 500 kHz = HF / (2 << code), 31.25 kHz = 500 kHz / 16
    localparam logic [6:0] MF_LOW_DIV   = 7'h10;

    // Start-up times in ns and the derived counts (rounded up)
    localparam int unsigned HF_START_NS  = 2000;
    localparam int unsigned LF_START_NS  = 100000;
    localparam int unsigned ADC_START_NS = 1000;
    localparam int unsigned HF_START_CYC  = (HF_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned LF_START_CYC  = (LF_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned ADC_START_CYC = (ADC_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : scs_pkg

// *** scs_osc_gen.sv ***
`timescale 1ns/1ps
`default_nettype none

// Behavioural oscillator: phase accumulator gives one-cycle ticks at the
// rate set by inc, and a ready flag after a start-up count while running.
module scs_osc_gen #(
    parameter int unsigned START_CYC = 80
) (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        run,
    input  wire logic [31:0] inc,
    output logic             tick,
    output logic             ready
);

    localparam int unsigned CW = $clog2(START_CYC + 1);
    localparam logic [CW-1:0] START_LAST = CW'(START_CYC);

    logic [31:0]   phase_reg;
    logic [31:0]   phase_next;
    logic          tick_reg;
    logic          tick_next;
    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;

    // Phase holds while stopped, so a restart carries on where it left off
    always_comb begin
        logic [32:0] sum;
        sum        = {1'b0, phase_reg} + {1'b0, inc};
        phase_next = phase_reg;
        tick_next  = 1'b0;
        cnt_next   = '0;
        if (run) begin
            phase_next = sum[31:0];
            tick_next  = sum[32];
            cnt_next   = (cnt_reg == START_LAST) ? cnt_reg : cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            phase_reg <= 32'h0000_0000;
            tick_reg  <= 1'b0;
            cnt_reg   <= '0;
        end else begin
            phase_reg <= phase_next;
            tick_reg  <= tick_next;
            cnt_reg   <= cnt_next;
        end
    end

    assign tick  = tick_reg;
    assign ready = run && (cnt_reg == START_LAST);

endmodule : scs_osc_gen

`default_nettype wire

// *** scs_clock_select.sv ***
`timescale 1ns/1ps
`default_nettype none

module scs_clock_select (
    input  wire logic        mclk,
    input  wire logic        rst,
    // Configuration straps
    input  wire logic [1:0]  reset_osc_select,
    input  wire logic        ext_clock_mode_select,
    input  wire logic        clock_out_enable_n,
    // Clock-in pin
    input  wire logic        ext_clock_in,
    output logic             ext_clock_in_is_gpio,
    output logic             ext_clock_in_gpio_value,
    // Clock-out pin, two-way
    input  wire logic        instr_clock_out_i,
    output logic             instr_clock_out_o,
    output logic             instr_clock_out_oe,
    input  wire logic        gpio_instr_clock_out_out,
    input  wire logic        gpio_instr_clock_out_oe,
    output logic             gpio_instr_clock_out_in,
    // Register port
    input  wire logic [11:0] reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [7:0]       reg_rdata,
    // Peripheral demands
    input  wire logic        hf_req,
    input  wire logic        mf_req,
    input  wire logic        lf_req,
    input  wire logic        adc_req,
    input  wire logic        timer_base_req,
    // Clock enables out
    output logic             sys_tick,
    output logic             instr_tick,
    output logic             hf_tick,
    output logic             mf_500k_tick,
    output logic             mf_31k_tick,
    output logic             lf_tick,
    output logic             timer_base_tick,
    output logic             adc_rc_tick,
    output logic             ext_clock_high_power,
    output logic             ext_clock_low_power
);

    // Frequency code to increment, with signed trim folded in
    function automatic logic [31:0] hf_inc_of(input logic [2:0] code, input logic [5:0] trim);
        logic [32:0] base;
        logic [32:0] step;
        logic [32:0] adj;
        logic [32:0] res;
        base = {1'b0, scs_pkg::HF_INC_1MHZ} << code;
        step = base >> scs_pkg::TRIM_SHIFT;
        if (trim[5]) begin
            adj = 33'(step * {27'h0, 6'h00 - trim});
            res = base - adj;
        end else begin
            adj = 33'(step * {27'h0, trim});
            res = base + adj;
        end
        return res[31:0];
    endfunction : hf_inc_of

    // Configuration latch and software registers
    logic       loaded_reg;
    logic       loaded_next;
    logic [1:0] src_reg;
    logic [1:0] src_next;
    logic       ext_hp_reg;
    logic       ext_hp_next;
    logic       instr_clock_out_n_reg;
    logic       instr_clock_out_n_next;
    logic [2:0] freq_reg;
    logic [2:0] freq_next;
    logic [5:0] trim_reg;
    logic [5:0] trim_next;
    logic [7:0] enable_reg;
    logic [7:0] enable_next;
    logic       snap;

    // Straps are caught on the first edge after reset release
    always_comb begin
        loaded_next   = 1'b1;
        src_next      = src_reg;
        ext_hp_next   = ext_hp_reg;
        instr_clock_out_n_next = instr_clock_out_n_reg;
        freq_next     = freq_reg;
        trim_next     = trim_reg;
        enable_next   = enable_reg;
        snap          = 1'b0;
        if (!loaded_reg) begin
            src_next      = reset_osc_select;
            ext_hp_next   = ext_clock_mode_select;
            instr_clock_out_n_next = clock_out_enable_n;
            freq_next     = (reset_osc_select == scs_pkg::SRC_HF_32M) ?
                            scs_pkg::FREQ_32M : scs_pkg::FREQ_16M;
            snap          = 1'b1;
        end else if (reg_wr) begin
            case (reg_addr)
                scs_pkg::OFS_FREQ: begin
                    // Reserved codes are dropped so the rate stays defined
                    if (reg_wdata[2:0] <= scs_pkg::FREQ_MAX) begin
                        freq_next = reg_wdata[2:0];
                        snap      = 1'b1;
                    end
                end
                scs_pkg::OFS_TRIM:   trim_next = reg_wdata[5:0];
                scs_pkg::OFS_ENABLE: enable_next = reg_wdata &
                    8'((1 << scs_pkg::BIT_HF) | (1 << scs_pkg::BIT_MF) |
                       (1 << scs_pkg::BIT_LF) | (1 << scs_pkg::BIT_ADC));
                default: ;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            loaded_reg   <= 1'b0;
            src_reg      <= scs_pkg::SRC_HF_32M;
            ext_hp_reg   <= 1'b0;
            instr_clock_out_n_reg <= 1'b1;
            freq_reg     <= scs_pkg::FREQ_RESET;
            trim_reg     <= scs_pkg::TRIM_RESET;
            enable_reg   <= scs_pkg::ENABLE_RESET;
        end else begin
            loaded_reg   <= loaded_next;
            src_reg      <= src_next;
            ext_hp_reg   <= ext_hp_next;
            instr_clock_out_n_reg <= instr_clock_out_n_next;
            freq_reg     <= freq_next;
            trim_reg     <= trim_next;
            enable_reg   <= enable_next;
        end
    end

    // Pin synchronisers: three stages, a change counts when stages 2 and 3 agree
    logic [1:0] s1_reg;
    logic [1:0] s2_reg;
    logic [1:0] s3_reg;
    logic [1:0] pin_reg;
    logic [1:0] pin_next;
    logic       ext_prev_reg;

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            pin_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : pin_reg[i];
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s1_reg       <= 2'h0;
            s2_reg       <= 2'h0;
            s3_reg       <= 2'h0;
            pin_reg      <= 2'h0;
            ext_prev_reg <= 1'b0;
        end else begin
            s1_reg       <= {instr_clock_out_i, ext_clock_in};
            s2_reg       <= s1_reg;
            s3_reg       <= s2_reg;
            pin_reg      <= pin_next;
            ext_prev_reg <= pin_reg[0];
        end
    end

    // Oscillator run requests
    logic sel_ext;
    logic sel_hf;
    logic sel_lf;
    logic hf_run;
    logic mf_run;
    logic lf_run;
    logic adc_run;
    logic hf_ready;
    logic lf_ready;
    logic adc_ready;
    logic mf_ready;

    assign sel_ext = loaded_reg && (src_reg == scs_pkg::SRC_EXT);
    assign sel_lf  = loaded_reg && (src_reg == scs_pkg::SRC_LF);
    assign sel_hf  = loaded_reg && !sel_ext && !sel_lf;
    // A demand-started oscillator stops again once nobody asks for it
    assign mf_run  = enable_reg[scs_pkg::BIT_MF] || mf_req;
    assign hf_run  = enable_reg[scs_pkg::BIT_HF] || hf_req || mf_run || sel_hf;
    assign lf_run  = enable_reg[scs_pkg::BIT_LF] || lf_req || timer_base_req || sel_lf;
    assign adc_run = enable_reg[scs_pkg::BIT_ADC] || adc_req;
    assign mf_ready = mf_run && hf_ready;

    // Trim slews the increment gradually; a frequency change snaps at once
    logic [31:0] hf_inc_reg;
    logic [31:0] hf_inc_next;
    logic [31:0] hf_target;

    assign hf_target = hf_inc_of(freq_next, trim_reg);

    always_comb begin
        if (snap) begin
            hf_inc_next = hf_target;
        end else if (hf_inc_reg < hf_target) begin
            hf_inc_next = (hf_target - hf_inc_reg > scs_pkg::TRIM_SLEW) ?
                          hf_inc_reg + scs_pkg::TRIM_SLEW : hf_target;
        end else begin
            hf_inc_next = (hf_inc_reg - hf_target > scs_pkg::TRIM_SLEW) ?
                          hf_inc_reg - scs_pkg::TRIM_SLEW : hf_target;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            hf_inc_reg <= 32'h0000_0000;
        end else begin
            hf_inc_reg <= hf_inc_next;
        end
    end

    scs_osc_gen #(.START_CYC(scs_pkg::HF_START_CYC)) u_hf (
        .mclk  (mclk),
        .rst   (rst),
        .run   (hf_run),
        .inc   (hf_inc_reg),
        .tick  (hf_tick),
        .ready (hf_ready)
    );

    // Low oscillator has a fixed increment, out of reach of the trim
    scs_osc_gen #(.START_CYC(scs_pkg::LF_START_CYC)) u_lf (
        .mclk  (mclk),
        .rst   (rst),
        .run   (lf_run),
        .inc   (scs_pkg::LF_INC),
        .tick  (lf_tick),
        .ready (lf_ready)
    );

    scs_osc_gen #(.START_CYC(scs_pkg::ADC_START_CYC)) u_adc (
        .mclk  (mclk),
        .rst   (rst),
        .run   (adc_run),
        .inc   (scs_pkg::ADC_INC),
        .tick  (adc_rc_tick),
        .ready (adc_ready)
    );

    assign timer_base_tick = lf_tick;

    // Medium-frequency dividers track the selected HF code
    logic [6:0] mf_cnt_reg;
    logic [6:0] mf_cnt_next;
    logic [3:0] mfl_cnt_reg;
    logic [3:0] mfl_cnt_next;
    logic       mf_hi_reg;
    logic       mf_hi_next;
    logic       mf_lo_reg;
    logic       mf_lo_next;
    logic [6:0] mf_div;

    assign mf_div = 7'h02 << freq_reg;

    always_comb begin
        mf_cnt_next  = mf_cnt_reg;
        mfl_cnt_next = mfl_cnt_reg;
        mf_hi_next   = 1'b0;
        mf_lo_next   = 1'b0;
        if (mf_run && hf_tick) begin
            if (mf_cnt_reg >= mf_div - 7'h01) begin
                mf_cnt_next  = 7'h00;
                mf_hi_next   = 1'b1;
                mfl_cnt_next = mfl_cnt_reg + 4'h1;
                mf_lo_next   = (mfl_cnt_reg == 4'(scs_pkg::MF_LOW_DIV - 7'h01));
            end else begin
                mf_cnt_next = mf_cnt_reg + 7'h01;
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            mf_cnt_reg  <= 7'h00;
            mfl_cnt_reg <= 4'h0;
            mf_hi_reg   <= 1'b0;
            mf_lo_reg   <= 1'b0;
        end else begin
            mf_cnt_reg  <= mf_cnt_next;
            mfl_cnt_reg <= mfl_cnt_next;
            mf_hi_reg   <= mf_hi_next;
            mf_lo_reg   <= mf_lo_next;
        end
    end

    assign mf_500k_tick = mf_hi_reg;
    assign mf_31k_tick  = mf_lo_reg;

    // System clock mux; medium clocks never reach it
    logic       sys_tick_c;
    logic [1:0] icnt_reg;
    logic [1:0] icnt_next;
    logic       ilevel_reg;
    logic       ilevel_next;
    logic       itick_reg;
    logic       itick_next;
    logic [3:0] hdiv_reg;
    logic [3:0] hdiv_next;
    logic       hf_sys;

    // The 1 MHz reset choice keeps the 16 MHz code and divides by 16 on the way in
    assign hdiv_next = hf_tick ? hdiv_reg + 4'h1 : hdiv_reg;
    assign hf_sys    = hf_tick &&
                       ((src_reg != scs_pkg::SRC_HF_1M) || (hdiv_reg == 4'hf));

    always_comb begin
        case (1'b1)
            sel_ext: sys_tick_c = pin_reg[0] && !ext_prev_reg;
            sel_lf:  sys_tick_c = lf_tick;
            sel_hf:  sys_tick_c = hf_sys;
            default: sys_tick_c = 1'b0;
        endcase
    end

    // Instruction clock: system ticks divided by four, held when ticks stop
    always_comb begin
        icnt_next   = icnt_reg;
        ilevel_next = ilevel_reg;
        itick_next  = 1'b0;
        if (sys_tick_c) begin
            icnt_next   = icnt_reg + 2'h1;
            ilevel_next = icnt_next[1];
            itick_next  = (icnt_reg == 2'h3);
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            icnt_reg   <= 2'h0;
            ilevel_reg <= 1'b0;
            itick_reg  <= 1'b0;
            hdiv_reg   <= 4'h0;
        end else begin
            hdiv_reg   <= hdiv_next;
            icnt_reg   <= icnt_next;
            ilevel_reg <= ilevel_next;
            itick_reg  <= itick_next;
        end
    end

    assign sys_tick   = sys_tick_c;
    assign instr_tick = itick_reg;

    // Pin functions
    assign instr_clock_out_o  = instr_clock_out_n_reg ? gpio_instr_clock_out_out : ilevel_reg;
    assign instr_clock_out_oe = instr_clock_out_n_reg ? gpio_instr_clock_out_oe : 1'b1;
    assign gpio_instr_clock_out_in     = pin_reg[1];
    assign ext_clock_in_is_gpio      = !sel_ext;
    assign ext_clock_in_gpio_value   = pin_reg[0];
    assign ext_clock_high_power = sel_ext && ext_hp_reg;
    assign ext_clock_low_power  = sel_ext && !ext_hp_reg;

    // Read port: data one cycle after the strobe, zero elsewhere
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;

    always_comb begin
        rdata_next = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                scs_pkg::OFS_CUR_SRC: rdata_next[scs_pkg::CUR_SRC_LSB +: 2] = src_reg;
                scs_pkg::OFS_STATUS: begin
                    rdata_next[scs_pkg::BIT_HF]  = hf_ready;
                    rdata_next[scs_pkg::BIT_MF]  = mf_ready;
                    rdata_next[scs_pkg::BIT_LF]  = lf_ready;
                    rdata_next[scs_pkg::BIT_ADC] = adc_ready;
                end
                scs_pkg::OFS_ENABLE:  rdata_next = enable_reg;
                scs_pkg::OFS_TRIM:    rdata_next = {2'h0, trim_reg};
                scs_pkg::OFS_FREQ:    rdata_next = {5'h00, freq_reg};
                default:              rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;

endmodule : scs_clock_select

`default_nettype wire

// *** scs_clock_select_sva.sv ***
`timescale 1ns/1ps
`default_nettype none

module scs_clock_select_sva (
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic [1:0]  reset_osc_select,
    input wire logic        ext_clock_mode_select,
    input wire logic        clock_out_enable_n,
    input wire logic        ext_clock_in,
    input wire logic        ext_clock_in_is_gpio,
    input wire logic        instr_clock_out_o,
    input wire logic        instr_clock_out_oe,
    input wire logic        gpio_instr_clock_out_out,
    input wire logic        gpio_instr_clock_out_oe,
    input wire logic [11:0] reg_addr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    input wire logic        sys_tick,
    input wire logic        instr_tick,
    input wire logic        lf_tick,
    input wire logic        timer_base_tick,
    input wire logic        ext_clock_high_power,
    input wire logic        ext_clock_low_power
);
    logic [1:0] up_reg, up_next;
    logic [2:0] n_reg, n_next;
    logic       sd_reg, seen_reg, seen_next, ext_ok;

    // Straps are trusted only from the fourth edge after reset, once capture has landed
    always_comb begin
        up_next   = (up_reg == 2'h3) ? up_reg : up_reg + 2'h1;
        n_next    = instr_tick ? 3'h0 : n_reg + 3'(sd_reg);
        seen_next = seen_reg | instr_tick;
    end

    // Delayed system edge lines up with the registered instruction edge
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            up_reg   <= 2'h0;
            n_reg    <= 3'h0;
            sd_reg   <= 1'b0;
            seen_reg <= 1'b0;
        end else begin
            up_reg   <= up_next;
            n_reg    <= n_next;
            sd_reg   <= sys_tick;
            seen_reg <= seen_next;
        end
    end

    assign ext_ok = (up_reg == 2'h3) && (reset_osc_select == scs_pkg::SRC_EXT);

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence s_ext_rise;
        (ext_ok && !ext_clock_in) ##1 ext_clock_in;
    endsequence
    sequence s_ext_still;
        (ext_ok && $stable(ext_clock_in)) [*8];
    endsequence

    a_ext_tick: assert property (s_ext_rise |-> ##[2:6] sys_tick)
        else $error("No system edge after clock-in rise");
    a_ext_halt: assert property (s_ext_still |-> !sys_tick)
        else $error("System edge while clock-in is still");
    a_instr_div: assert property (seen_reg && instr_tick |-> 3'(n_reg + 3'(sd_reg)) == 3'h4)
        else $error("Instruction edge not every fourth system edge");
    a_instr_clock_out_drive: assert property (up_reg == 2'h3 && !clock_out_enable_n |-> instr_clock_out_oe)
        else $error("Clock-out pin not driven");
    a_instr_clock_out_free: assert property (up_reg == 2'h3 && clock_out_enable_n |->
        instr_clock_out_oe == gpio_instr_clock_out_oe && instr_clock_out_o == gpio_instr_clock_out_out)
        else $error("Clock-out pin not released");
    a_ext_clock_in_free: assert property (up_reg == 2'h3 |->
        ext_clock_in_is_gpio == (reset_osc_select != scs_pkg::SRC_EXT))
        else $error("Clock-in pin use wrong");
    a_ext_power: assert property (up_reg == 2'h3 |-> {ext_clock_high_power, ext_clock_low_power}
        == (ext_ok ? {ext_clock_mode_select, !ext_clock_mode_select} : 2'b00))
        else $error("External power mode wrong");
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("Read data outside answer cycle");
    a_freq_range: assert property ($past(reg_rd) && $past(reg_addr) == scs_pkg::OFS_FREQ |->
        reg_rdata[7:3] == 5'h00 && reg_rdata[2:0] <= scs_pkg::FREQ_MAX)
        else $error("Frequency code out of range");
    a_timer_base: assert property (timer_base_tick == lf_tick)
        else $error("Timer base not the low oscillator");
endmodule : scs_clock_select_sva

bind scs_clock_select scs_clock_select_sva i_sva (.*);

`default_nettype wire

// *** scs_ext_src.sv ***
`timescale 1ns/1ps
`default_nettype none

module scs_ext_src #(
    parameter int HALF_NS = 100
) (
    input  wire logic run,
    output logic      clk_o
);
    // A stopped source holds its level, so a stall is seen as a still pin
    initial clk_o = 1'b0;
    always begin
        #(HALF_NS);
        if (run) clk_o = ~clk_o;
    end
endmodule : scs_ext_src

`default_nettype wire

// *** scs_clock_select_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin mismatches++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, a, b); end end

module scs_clock_select_tb;
    logic        mclk, rst, ext_clock_mode_select, clock_out_enable_n, ext_clock_in, ext_run;
    logic        ext_clock_in_is_gpio, ext_clock_in_gpio_value, instr_clock_out_o, instr_clock_out_oe, pad_v;
    logic        gpio_instr_clock_out_out, gpio_instr_clock_out_oe, gpio_instr_clock_out_in, reg_wr, reg_rd, adc_req;
    logic        hf_req, mf_req, lf_req, timer_base_req, sys_tick, instr_tick, hf_tick;
    logic        mf_500k_tick, mf_31k_tick, lf_tick, timer_base_tick, adc_rc_tick;
    logic        ext_clock_high_power, ext_clock_low_power;
    wire logic   instr_clock_out_i;
    logic [1:0]  reset_osc_select;
    logic [11:0] reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, d;
    int          mismatches, comparisons;
    integer      s, h, m, q, l, h0, l0;
    int unsigned seed, r;

    scs_clock_select i_dut (.*);
    scs_ext_src i_src (.run(ext_run), .clk_o(ext_clock_in));
    // Pin level as every party sees it
    assign instr_clock_out_i = instr_clock_out_oe ? instr_clock_out_o : pad_v;

    always #12.5 mclk = ~mclk;

    function automatic int unsigned xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    function automatic int rate(input int n, input longint unsigned hz);
        return int'(n * hz / scs_pkg::CLK_HZ);
    endfunction : rate
    function automatic logic near(input integer a, input int e, input int t);
        return (a >= e - t) && (a <= e + t);
    endfunction : near

    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
        @(posedge mclk);
    endtask : wr
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [11:0] a);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
        @(posedge mclk);
    endtask : rd
    task automatic count(input int n);
        {s, h, m, q, l} = 160'd0;
        repeat (n) begin
            @(posedge mclk);
            #1;
            s += sys_tick;
            h += hf_tick;
            m += mf_500k_tick;
            q += mf_31k_tick;
            l += lf_tick;
        end
    endtask : count
    task automatic do_reset(input logic [1:0] c);
        r = xs();
        rst                   <= 1'b1;
        reset_osc_select      <= c;
        ext_clock_mode_select <= (c != scs_pkg::SRC_EXT) && r[0]; // Source is 5 MHz
        clock_out_enable_n    <= r[1];
        gpio_instr_clock_out_out       <= r[2];
        gpio_instr_clock_out_oe        <= r[3];
        pad_v                 <= r[4];
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask : do_reset
    task automatic give_verdict();
        $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : give_verdict

    // Watchdog at 96k cycles, above the planned run of about 83k cycles
    initial begin
        #2_400_000;
        mismatches++;
        give_verdict();
    end

    initial begin
        {mclk, ext_run, reg_wr, reg_rd, hf_req, mf_req, lf_req, adc_req, timer_base_req} = '0;
        {reset_osc_select, ext_clock_mode_select, clock_out_enable_n, reg_addr, reg_wdata} = '0;
        {gpio_instr_clock_out_out, gpio_instr_clock_out_oe, pad_v, mismatches, comparisons} = '0;
        rst  = 1'b1;
        seed = 1;
        for (int c = 3; c >= 0; c--) begin
            do_reset(2'(c));
            rd(scs_pkg::OFS_CUR_SRC);
            `CHK(d, 8'(c << scs_pkg::CUR_SRC_LSB))
            rd(scs_pkg::OFS_FREQ);
            `CHK(d, (c == 0) ? 8'h05 : 8'h04)
            rd(scs_pkg::OFS_TRIM);
            `CHK(d, 8'h00)
            rd(scs_pkg::OFS_ENABLE);
            `CHK(d, 8'h00)
            rd(12'h88f);
            `CHK(d, 8'h00)
            if (c == 3) begin
                ext_run <= 1'b1;
                count(4000);
                `CHK(near(s, 500, 3), 1'b1)
                ext_run <= 1'b0;
                count(10);
                count(200);
                `CHK(s, 0)
                `CHK({gpio_instr_clock_out_in, ext_clock_in_gpio_value}, {instr_clock_out_i, ext_clock_in})
                ext_run <= 1'b1;
                count(400);
                `CHK(near(s, 50, 3), 1'b1)
                ext_run <= 1'b0;
            end else begin
                count(c == 1 ? 16000 : 4000);
                `CHK(near(s, c == 1 ? rate(16000, scs_pkg::LF_HZ) :
                    rate(4000, scs_pkg::HF_BASE_HZ << (c == 2 ? 0 : 5)), 3), 1'b1)
            end
        end
        wr(scs_pkg::OFS_ENABLE, 8'hff);
        rd(scs_pkg::OFS_ENABLE);
        `CHK(d, 8'h74)
        for (int f = 0; f < 6; f++) begin
            wr(scs_pkg::OFS_FREQ, 8'(f));
            rd(scs_pkg::OFS_FREQ);
            `CHK(d, 8'(f))
            count(2000);
            `CHK(near(h, rate(2000, scs_pkg::HF_BASE_HZ << f), 3), 1'b1)
            `CHK(near(m, 25, 1), 1'b1)
        end
        wr(scs_pkg::OFS_FREQ, 8'h06);
        wr(scs_pkg::OFS_FREQ, 8'h07);
        rd(scs_pkg::OFS_FREQ);
        `CHK(d, 8'h05)
        // Trim slews slowly, so each setting gets a settling span first
        wr(scs_pkg::OFS_FREQ, 8'h00);
        count(6000);
        h0 = h;
        l0 = l;
        `CHK(near(h0, 150, 3), 1'b1)
        `CHK(near(q, 5, 1), 1'b1)
        wr(scs_pkg::OFS_TRIM, 8'h1f);
        rd(scs_pkg::OFS_TRIM);
        `CHK(d, 8'h1f)
        count(7000);
        count(6000);
        `CHK(h > h0 + 5, 1'b1)
        `CHK(near(l, l0, 1), 1'b1)
        wr(scs_pkg::OFS_TRIM, 8'h20);
        count(13500);
        count(6000);
        `CHK(h < h0 - 5, 1'b1)
        wr(scs_pkg::OFS_ENABLE, 8'h00);
        r = xs();
        {hf_req, mf_req, lf_req, adc_req} <= r[3:0];
        count(4100);
        rd(scs_pkg::OFS_STATUS);
        `CHK(d, {1'b0, 1'b1, r[2], r[1], 1'b0, r[0], 2'b00})
        {hf_req, mf_req, lf_req, adc_req} <= 4'h0;
        count(2);
        rd(scs_pkg::OFS_STATUS);
        `CHK(d, 8'h40)
        give_verdict();
    end
endmodule : scs_clock_select_tb

`default_nettype wire
